//--- pkg/amfs_pkg.sv
`default_nettype none
package amfs_pkg;

   localparam int N_CH      = 10;
   localparam int MAX_RAILS = 2;
   localparam int CLK_PS    = 5000;
   localparam int CYC_PER_US = 1000000 / CLK_PS;

   // Times as printed, then cycle counts at the pclk rate.
   localparam int T_ADC_NS       = 3840;
   localparam int ADC_CYC        = (T_ADC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int T_VOUT_US      = 200;
   localparam int VOUT_CYC       = T_VOUT_US * CYC_PER_US;
   localparam int T_VIN_MS       = 1;
   localparam int VIN_CYC        = T_VIN_MS * 1000 * CYC_PER_US;
   localparam int T_TEMP_MS      = 100;
   localparam int TEMP_CYC       = T_TEMP_MS * 1000 * CYC_PER_US;
   localparam int T_HIZ_NS       = 5500;
   localparam int HIZ_CYC        = (T_HIZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int T_FLT_US       = 18;
   localparam int FLT_CYC        = T_FLT_US * CYC_PER_US;
   localparam int T_STORE_MS     = 10;
   localparam int STORE_STALL_CYC = T_STORE_MS * 1000 * CYC_PER_US;
   localparam int T_LOG_STALL_US = 550;
   localparam int LOG_STALL_CYC  = T_LOG_STALL_US * CYC_PER_US;
   localparam int T_TIMEOUT_MS   = 35;
   localparam int TIMEOUT_CYC    = T_TIMEOUT_MS * 1000 * CYC_PER_US;
   localparam int T_IDLE_MS      = 50;
   localparam int IDLE_CYC       = T_IDLE_MS * 1000 * CYC_PER_US;

   // Register byte offsets, then page numbers in address bits 7:6.
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_FILTER  = 8'h08;
   localparam logic [7:0] REG_RESP    = 8'h0C;
   localparam logic [1:0] REG_LIMIT_PAGE  = 2'h1;
   localparam logic [1:0] REG_RESULT_PAGE = 2'h2;

   // Field positions.
   localparam int CTRL_RAILS2_BIT = 0;
   localparam int CTRL_EN_LSB     = 1;
   localparam int CTRL_DRV_LSB    = 3;
   localparam int ST_WARN_LSB     = 10;
   localparam int ST_SHUT_LSB     = 20;
   localparam int ST_TO_BIT       = 22;
   localparam int ST_IDLE_BIT     = 23;
   localparam int LIM_WARN_LSB    = 12;
   localparam int LIM_UNDER_BIT   = 24;
   localparam int LIM_GAIN_LSB    = 25;

   // Reset values, then the driver setting that floats the output.
   localparam logic [10:0] CTRL_RST   = 11'h007;
   localparam logic [3:0]  FILTER_RST = 4'h2;
   localparam logic [19:0] RESP_RST   = 20'h55555;
   localparam logic [31:0] LIMIT_RST  = 32'h80FF_FFFF;
   localparam logic [7:0]  DRV_HIZ    = 8'h01;

   // Channel classes: 0/2 output voltage, 1/3 output current, then shared.
   localparam logic [9:0] VOUT_MASK = 10'h005;
   localparam logic [9:0] IOUT_MASK = 10'h00A;
   localparam logic [9:0] VIN_MASK  = 10'h010;
   localparam logic [9:0] IIN_MASK  = 10'h020;
   localparam logic [9:0] SLOW_MASK = 10'h3C0;
   localparam logic [9:0] CUR_MASK  = 10'h02A;
   localparam logic [9:0] ONE_RAIL_MASK = 10'h3F3;

   typedef enum logic [1:0] {RESP_IGNORE, RESP_SHUT_RAIL, RESP_SHUT_ALL, RESP_SPARE} amfs_resp_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } amfs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } amfs_apb_rsp_t;

   typedef struct packed {
      logic [3:0]              slot;
      logic [9:0]              adc_tmr;
      logic                    adc_start;
      logic [3:0]              adc_ch;
      logic [N_CH-1:0][11:0]   hold;
      logic [N_CH-1:0][15:0]   avg;
      logic [24:0]             t_vout;
      logic [24:0]             t_ms;
      logic [24:0]             t_slow;
      logic                    rail_tick;
      logic [N_CH-1:0]         due;
      logic [24:0]             stall;
      logic [N_CH-1:0]         fault_det;
      logic [MAX_RAILS-1:0]    act_rails;
      logic [10:0]             ctrl;
      logic [3:0]              filt;
      logic [19:0]             resp;
      logic [N_CH-1:0][31:0]   limit;
      logic [N_CH-1:0]         fault_st;
      logic [N_CH-1:0]         warn_st;
      logic                    to_st;
      logic                    idle_st;
      logic [MAX_RAILS-1:0]    shut;
      logic [MAX_RAILS-1:0]    hiz;
      logic [MAX_RAILS-1:0][10:0] hiz_cnt;
      logic [MAX_RAILS-1:0]    pwm_en;
      logic [5:0][2:0]         sync;
      logic [5:0]              lvl;
      logic [24:0]             low_cnt;
      logic [24:0]             high_cnt;
      logic                    bus_abort;
      logic                    bus_idle_reset;
      amfs_apb_rsp_t           apb;
   } amfs_state_t;

endpackage
`default_nettype wire

//--- hdl/amfs_supervisor.sv
// Operation
// - Endless sequence over rail and shared channels.
// - Samples per pass equal twice rails plus six.
// - Each conversion lasts 3.84 microseconds.
// - Scale averaged results, compare fault and warning.
// - Check timers run apart from the sequencer.
// - Output voltage checked every 200 microseconds.
// - Output current checked every 200 us times rails.
// - Input voltage and current checked every millisecond.
// - Temperatures and auxiliary inputs checked every 100 ms.
// - Detected fault: look up response, decide, execute.
// - Voltage fault answered within 250 or 800 us.
// - Voltage fault while logging within 800 or 1000 us.
// - Voltage fault during ramp within 400 us.
// - Current fault answered within 100+600*rails us.
// - Current fault while logging within 600+600*rails us.
// - Driver setting 0x01 floats output 5.5 us after shutdown.
// - Full configuration save delays detection 10 ms at most.
// - Currents pass a smoothing average before comparison.
// - External fault pin disables output within 18 us.
// - Current comparator disables output within five cycles.
// - Bus clock low over 35 ms abandons transaction.
// - Bus idle high over 50 ms resets transaction.
`timescale 1ns/1ps
`default_nettype none
module amfs_supervisor #(
   parameter int VOUT_CYCLES    = amfs_pkg::VOUT_CYC,
   parameter int VIN_CYCLES     = amfs_pkg::VIN_CYC,
   parameter int TEMP_CYCLES    = amfs_pkg::TEMP_CYC,
   parameter int STORE_STALL    = amfs_pkg::STORE_STALL_CYC,
   parameter int LOG_STALL      = amfs_pkg::LOG_STALL_CYC,
   parameter int TIMEOUT_CYCLES = amfs_pkg::TIMEOUT_CYC,
   parameter int IDLE_CYCLES    = amfs_pkg::IDLE_CYC
) (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            ce,
   input  wire amfs_pkg::amfs_apb_req_t         apb_req,
   output var  amfs_pkg::amfs_apb_rsp_t         apb_rsp,
   input  wire logic [11:0]                     adc_data,
   output logic                                 adc_start,
   output logic [3:0]                           adc_channel,
   input  wire logic                            nvm_logging,
   input  wire logic                            nvm_store_all,
   input  wire logic [amfs_pkg::MAX_RAILS-1:0]  fault_pin,
   input  wire logic [amfs_pkg::MAX_RAILS-1:0]  cs_comparator,
   input  wire logic                            bus_clk_in,
   input  wire logic                            bus_data_in,
   output logic [amfs_pkg::MAX_RAILS-1:0]       pulse_width_output_en,
   output logic [amfs_pkg::MAX_RAILS-1:0]       pulse_width_output_hiz,
   output logic                                 bus_abort,
   output logic                                 bus_idle_reset
);
   import amfs_pkg::*;

   amfs_state_t s_reg;
   amfs_state_t s_next;

   logic                  rails2;
   logic [9:0]            active;
   logic [3:0]            seq_len;
   logic                  slot_end;
   logic [N_CH-1:0]       over_f;
   logic [N_CH-1:0]       over_w;
   logic                  blocked;
   logic                  evaluate;
   logic [24:0]           stall_max;
   logic signed [16:0]    diff;
   logic [3:0]            shift;
   logic [3:0]            nxt_slot;
   logic [3:0]            ridx;
   logic                  acc;
   logic                  hit;
   logic [31:0]           rdata;
   logic [1:0]            code;
   logic [MAX_RAILS-1:0]  ch_rails;
   logic [5:0]            pins;

   assign rails2   = s_reg.ctrl[CTRL_RAILS2_BIT];
   assign active   = rails2 ? 10'h3FF : ONE_RAIL_MASK;
   assign seq_len  = rails2 ? 4'hA : 4'h8;
   assign slot_end = (s_reg.adc_tmr == 10'(ADC_CYC - 1));
   assign ridx     = apb_req.paddr[5:2];
   assign acc      = apb_req.psel && apb_req.penable;
   assign pins     = {bus_data_in, bus_clk_in, cs_comparator, fault_pin};

   // Scaling to units and limit compare, one copy per channel.
   for (genvar c = 0; c < N_CH; c++)
   begin : g_cmp
      logic [11:0] meas;
      logic [18:0] prod;
      logic [12:0] conv;
      logic        under;
      assign meas  = s_reg.avg[c][15:4];
      assign prod  = meas * s_reg.limit[c][31:LIM_GAIN_LSB];
      assign conv  = prod[18:6];
      assign under = s_reg.limit[c][LIM_UNDER_BIT];
      assign over_f[c] = under ? (conv < {1'b0, s_reg.limit[c][11:0]})
                               : (conv > {1'b0, s_reg.limit[c][11:0]});
      assign over_w[c] = under ? (conv < {1'b0, s_reg.limit[c][23:LIM_WARN_LSB]})
                               : (conv > {1'b0, s_reg.limit[c][23:LIM_WARN_LSB]});
   end

   // Detection may be held off by nonvolatile writes, but only for a bounded time.
   assign blocked   = nvm_store_all || nvm_logging;
   assign stall_max = nvm_store_all ? 25'(STORE_STALL - 1) : 25'(LOG_STALL - 1);
   assign evaluate  = (|s_reg.due) && (!blocked || s_reg.stall >= stall_max);

   always_comb
   begin
      s_next = s_reg;
      diff = 17'sh0;
      shift = 4'h0;
      nxt_slot = 4'h0;
      hit = 1'b0;
      rdata = 32'h0;
      code = 2'h0;
      ch_rails = '0;

      // Conversion sequencer.
      s_next.adc_start = 1'b0;
      if (slot_end)
      begin
         s_next.adc_tmr = 10'h0;
         s_next.hold[s_reg.adc_ch] = adc_data;
         shift = CUR_MASK[s_reg.adc_ch] ? s_reg.filt : 4'h0;
         diff = $signed({1'b0, adc_data, 4'h0}) - $signed({1'b0, s_reg.avg[s_reg.adc_ch]});
         s_next.avg[s_reg.adc_ch] = s_reg.avg[s_reg.adc_ch] + 16'(diff >>> shift);
         nxt_slot = (s_reg.slot >= seq_len - 4'h1) ? 4'h0 : s_reg.slot + 4'h1;
         s_next.slot = nxt_slot;
         s_next.adc_ch = (nxt_slot < {rails2, 2'b10}) ? nxt_slot : nxt_slot + (rails2 ? 4'h0 : 4'h2);
         s_next.adc_start = 1'b1;
      end
      else
      begin
         s_next.adc_tmr = s_reg.adc_tmr + 10'h1;
      end

      // Monitor interval timers, free of the sequencer.
      if (evaluate)
      begin
         s_next.fault_st = s_reg.fault_st | (s_reg.due & active & over_f);
         s_next.warn_st = s_reg.warn_st | (s_reg.due & active & over_w);
         s_next.fault_det = s_reg.due & active & over_f;
         s_next.due = '0;
      end
      else
      begin
         s_next.fault_det = '0;
      end
      s_next.stall = ((|s_reg.due) && blocked && !evaluate) ? s_reg.stall + 25'h1 : 25'h0;

      if (s_reg.t_vout >= 25'(VOUT_CYCLES - 1))
      begin
         s_next.t_vout = 25'h0;
         s_next.due = s_next.due | VOUT_MASK;
         if (!rails2 || s_reg.rail_tick)
         begin
            s_next.due = s_next.due | IOUT_MASK;
         end
         s_next.rail_tick = rails2 && !s_reg.rail_tick;
      end
      else
      begin
         s_next.t_vout = s_reg.t_vout + 25'h1;
      end
      if (s_reg.t_ms >= 25'(VIN_CYCLES - 1))
      begin
         s_next.t_ms = 25'h0;
         s_next.due = s_next.due | VIN_MASK | IIN_MASK;
      end
      else
      begin
         s_next.t_ms = s_reg.t_ms + 25'h1;
      end
      if (s_reg.t_slow >= 25'(TEMP_CYCLES - 1))
      begin
         s_next.t_slow = 25'h0;
         s_next.due = s_next.due | SLOW_MASK;
      end
      else
      begin
         s_next.t_slow = s_reg.t_slow + 25'h1;
      end

      // Response lookup: each detected fault picks its rails from its code.
      s_next.act_rails = '0;
      for (int c = 0; c < N_CH; c++)
      begin
         code = s_reg.resp[2*c +: 2];
         ch_rails = (c < 2 * MAX_RAILS) ? MAX_RAILS'(1 << (c / 2)) : '1;
         if (s_reg.fault_det[c] && code == RESP_SHUT_RAIL)
         begin
            s_next.act_rails = s_next.act_rails | ch_rails;
         end
         else if (s_reg.fault_det[c] && code == RESP_SHUT_ALL)
         begin
            s_next.act_rails = '1;
         end
      end

      // Pin synchronisers: three stages, a change counts when stages two and three agree.
      for (int p = 0; p < 6; p++)
      begin
         s_next.sync[p] = {s_reg.sync[p][1:0], pins[p]};
         if (s_reg.sync[p][1] == s_reg.sync[p][2])
         begin
            s_next.lvl[p] = s_reg.sync[p][2];
         end
      end

      // Bus timeouts.
      s_next.bus_abort = 1'b0;
      s_next.bus_idle_reset = 1'b0;
      s_next.low_cnt = s_reg.lvl[4] ? 25'h0 : s_reg.low_cnt + ((s_reg.low_cnt < 25'(TIMEOUT_CYCLES)) ? 25'h1 : 25'h0);
      if (!s_reg.lvl[4] && s_reg.low_cnt == 25'(TIMEOUT_CYCLES - 1))
      begin
         s_next.bus_abort = 1'b1;
         s_next.to_st = 1'b1;
      end
      s_next.high_cnt = !(s_reg.lvl[4] && s_reg.lvl[5]) ? 25'h0
                        : s_reg.high_cnt + ((s_reg.high_cnt <= 25'(IDLE_CYCLES)) ? 25'h1 : 25'h0);
      if (s_reg.lvl[4] && s_reg.lvl[5] && s_reg.high_cnt == 25'(IDLE_CYCLES))
      begin
         s_next.bus_idle_reset = 1'b1;
         s_next.idle_st = 1'b1;
      end

      // APB slave: one wait state, writes take effect at the completing edge.
      if (apb_req.paddr == REG_CTRL)
      begin
         hit = 1'b1;
         rdata = {21'h0, s_reg.ctrl};
      end
      else if (apb_req.paddr == REG_STATUS)
      begin
         hit = 1'b1;
         rdata = {8'h0, s_reg.idle_st, s_reg.to_st, s_reg.shut, s_reg.warn_st, s_reg.fault_st};
      end
      else if (apb_req.paddr == REG_FILTER)
      begin
         hit = 1'b1;
         rdata = {28'h0, s_reg.filt};
      end
      else if (apb_req.paddr == REG_RESP)
      begin
         hit = 1'b1;
         rdata = {12'h0, s_reg.resp};
      end
      else if (apb_req.paddr[7:6] == REG_LIMIT_PAGE && apb_req.paddr[1:0] == 2'h0 && ridx < 4'(N_CH))
      begin
         hit = 1'b1;
         rdata = s_reg.limit[ridx];
      end
      else if (apb_req.paddr[7:6] == REG_RESULT_PAGE && apb_req.paddr[1:0] == 2'h0 && ridx < 4'(N_CH))
      begin
         hit = 1'b1;
         rdata = {s_reg.avg[ridx], 4'h0, s_reg.hold[ridx]};
      end

      s_next.apb.pready = 1'b0;
      if (acc && !s_reg.apb.pready)
      begin
         s_next.apb.pready = 1'b1;
         s_next.apb.prdata = apb_req.pwrite ? 32'h0 : rdata;
         s_next.apb.pslverr = !hit;
      end
      if (acc && s_reg.apb.pready && apb_req.pwrite && hit)
      begin
         if (apb_req.paddr == REG_CTRL)
         begin
            s_next.ctrl = apb_req.pwdata[10:0];
         end
         else if (apb_req.paddr == REG_STATUS)
         begin
            // Write one to clear; a flag set in this same cycle survives.
            s_next.fault_st = s_next.fault_st & ~(apb_req.pwdata[9:0] & ~(s_reg.due & active & over_f
                              & {N_CH{evaluate}}));
            s_next.warn_st = s_next.warn_st & ~(apb_req.pwdata[19:10] & ~(s_reg.due & active & over_w
                             & {N_CH{evaluate}}));
            s_next.to_st = s_next.to_st & ~(apb_req.pwdata[ST_TO_BIT] && !s_next.bus_abort);
            s_next.idle_st = s_next.idle_st & ~(apb_req.pwdata[ST_IDLE_BIT] && !s_next.bus_idle_reset);
            s_next.shut = s_reg.shut & ~apb_req.pwdata[ST_SHUT_LSB +: MAX_RAILS];
         end
         else if (apb_req.paddr == REG_FILTER)
         begin
            s_next.filt = apb_req.pwdata[3:0];
         end
         else if (apb_req.paddr == REG_RESP)
         begin
            s_next.resp = apb_req.pwdata[19:0];
         end
         else if (apb_req.paddr[7:6] == REG_LIMIT_PAGE)
         begin
            s_next.limit[ridx] = apb_req.pwdata;
         end
      end

      // Shutdown execution, hardware fault paths and output float timing.
      for (int r = 0; r < MAX_RAILS; r++)
      begin
         if (s_reg.act_rails[r] || s_reg.lvl[r] || (r == 0 && s_reg.lvl[2]) || (r == 1 && s_reg.lvl[3]))
         begin
            s_next.shut[r] = 1'b1;
         end
         if (!s_reg.shut[r])
         begin
            s_next.hiz_cnt[r] = 11'h0;
            s_next.hiz[r] = 1'b0;
         end
         else if (s_reg.hiz_cnt[r] < 11'(HIZ_CYC - 1))
         begin
            s_next.hiz_cnt[r] = s_reg.hiz_cnt[r] + 11'h1;
         end
         else
         begin
            s_next.hiz[r] = (s_reg.ctrl[CTRL_DRV_LSB +: 8] == DRV_HIZ);
         end
         s_next.pwm_en[r] = s_reg.ctrl[CTRL_EN_LSB + r] && !s_next.shut[r] && (r == 0 || rails2);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.ctrl <= CTRL_RST;
         s_reg.filt <= FILTER_RST;
         s_reg.resp <= RESP_RST;
         s_reg.limit <= {N_CH{LIMIT_RST}};
         s_reg.lvl <= 6'h30;
         s_reg.sync <= {3'h7, 3'h7, 12'h000};
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   assign apb_rsp                = s_reg.apb;
   assign adc_start              = s_reg.adc_start;
   assign adc_channel            = s_reg.adc_ch;
   assign pulse_width_output_en  = s_reg.pwm_en;
   assign pulse_width_output_hiz = s_reg.hiz;
   assign bus_abort              = s_reg.bus_abort;
   assign bus_idle_reset         = s_reg.bus_idle_reset;

   // Helper for checks: cycles since the previous conversion start.
   logic [10:0] start_gap;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_gap <= 11'h0;
      end
      else if (ce)
      begin
         start_gap <= adc_start ? 11'h1 : start_gap + 11'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   localparam int FLT_LAT = 3;

   sequence detect_s;
      s_reg.fault_det[0] && s_reg.resp[1:0] == RESP_SHUT_RAIL;
   endsequence
   sequence decide_exec_s;
      ##1 s_reg.act_rails[0] ##1 s_reg.shut[0] && !pulse_width_output_en[0];
   endsequence

   slot_wrap_a: assert property (s_reg.slot < seq_len) else $error("slot beyond pass length");
   adc_period_a: assert property (adc_start && $past(s_reg.slot) != 4'h0 |-> start_gap == 11'(ADC_CYC))
      else $error("conversion period wrong");
   hold_capture_a: assert property (slot_end |=> s_reg.hold[$past(s_reg.adc_ch)] == $past(adc_data))
      else $error("holding register not updated");
   vout_due_a: assert property (s_reg.t_vout == 25'(VOUT_CYCLES - 1) |=> s_reg.due[0] || $past(evaluate))
      else $error("output voltage check not scheduled");
   response_chain_a: assert property (detect_s |-> decide_exec_s)
      else $error("fault response not executed");
   hiz_delay_a: assert property ($rose(s_reg.hiz[0]) |-> s_reg.hiz_cnt[0] == 11'(HIZ_CYC - 1) && s_reg.shut[0])
      else $error("output floated at wrong time");
   fault_pin_a: assert property ($rose(s_reg.lvl[1]) |-> ##[1:FLT_LAT] !pulse_width_output_en[1])
      else $error("fault pin did not disable output");
   comparator_a: assert property ($rose(s_reg.lvl[2]) |-> ##2 !pulse_width_output_en[0])
      else $error("comparator did not disable output");
   bus_abort_a: assert property (bus_abort |-> !s_reg.lvl[4] && s_reg.low_cnt == 25'(TIMEOUT_CYCLES))
      else $error("bus abort without long clock low");
   idle_reset_a: assert property (bus_idle_reset |-> s_reg.lvl[4] && s_reg.lvl[5] && $past(s_reg.high_cnt) == 25'(IDLE_CYCLES))
      else $error("idle reset without idle bus");

endmodule
`default_nettype wire

//--- bench/amfs_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module amfs_adc_model (
   input  wire logic        pclk,
   input  wire logic [3:0]  adc_channel,
   input  wire logic [11:0] vout0_level,
   output logic [11:0]      adc_data
);
   // Rail 0 voltage follows the bench level; every other input sits low and quiet.
   always_ff @(posedge pclk)
   begin
      adc_data <= (adc_channel == 4'h0) ? vout0_level : 12'h010;
   end
endmodule
`default_nettype wire

//--- bench/tb_adc_monitor_fault_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_monitor_fault_supervisor;
   import amfs_pkg::*;
   logic           pclk = 1'b0;
   logic           presetn;
   amfs_apb_req_t  req;
   amfs_apb_rsp_t  rsp;
   logic [11:0]    adc_data;
   logic [11:0]    v0;
   logic           adc_start;
   logic [3:0]     adc_ch;
   logic [1:0]     fpin;
   logic [1:0]     csc;
   logic [1:0]     en;
   logic [1:0]     hiz;
   logic           bclk;
   logic           bdat;
   logic           ce;
   logic           nvm_log;
   logic           nvm_all;
   logic           abort;
   logic           idle;
   logic [31:0]    rdv;
   logic [9:0]     seen;
   int             n_mismatch = 0;
   int             cmp_count = 0;
   int             n;

   initial
   begin
      forever #2.5 pclk = ~pclk;
   end

   amfs_supervisor #(.VOUT_CYCLES(200), .STORE_STALL(500), .LOG_STALL(100), .TIMEOUT_CYCLES(300),
      .IDLE_CYCLES(400)) uut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp), .adc_data(adc_data),
      .adc_start(adc_start), .adc_channel(adc_ch), .nvm_logging(nvm_log), .nvm_store_all(nvm_all),
      .fault_pin(fpin), .cs_comparator(csc), .bus_clk_in(bclk), .bus_data_in(bdat),
      .pulse_width_output_en(en), .pulse_width_output_hiz(hiz), .bus_abort(abort), .bus_idle_reset(idle));

   amfs_adc_model adc (.pclk(pclk), .adc_channel(adc_ch), .vout0_level(v0), .adc_data(adc_data));

   task report_and_stop;
   begin
      $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   // One APB transfer; the request stands until pready is sampled high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp, input logic err);
      int i;
   begin
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      for (i = 0; i < 50 && rsp.pready !== 1'b1; i++) @(posedge pclk);
      if (rsp.pready !== 1'b1)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t pready got=%h exp=%h", $time, rsp.pready, 1'b1);
         report_and_stop;
      end
      rdv = rsp.prdata;
      chk({31'h0, rsp.pslverr}, {31'h0, err});
      if (!w) chk(rdv, exp);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   end
   endtask

   task waitfor(input int sel, input int bound);
      logic hit;
   begin
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
         case (sel)
            0: hit = (en[0] === 1'b0);
            1: hit = (en[1] === 1'b0);
            2: hit = (abort === 1'b1);
            3: hit = (idle === 1'b1);
            4: hit = (hiz[0] === 1'b1);
            default: hit = (adc_start === 1'b1);
         endcase
      end while (!hit && n < bound);
      if (!hit)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t wait %0h got=%h exp=%h", $time, sel, n, bound);
         report_and_stop;
      end
   end
   endtask

   task seq(input int cnt, input logic [9:0] exp);
      int k;
   begin
      seen = '0;
      for (k = 0; k < cnt; k++)
      begin
         waitfor(5, 1000);
         if (k > 0) chk(32'(n), 32'(ADC_CYC));
         seen[adc_ch] = 1'b1;
      end
      chk(32'(seen), 32'(exp));
   end
   endtask

   initial
   begin
      presetn = 1'b0;
      req = '0;
      v0 = 12'h010;
      fpin = 2'b00;
      csc = 2'b00;
      bclk = 1'b1;
      bdat = 1'b1;
      ce = 1'b1;
      nvm_log = 1'b0;
      nvm_all = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0, 32'(CTRL_RST), 1'b0);
      apb(1'b0, REG_RESP, 32'h0, 32'(RESP_RST), 1'b0);
      apb(1'b0, 8'h40, 32'h0, LIMIT_RST, 1'b0);
      apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
      seq(N_CH, 10'h3FF);
      apb(1'b1, REG_CTRL, 32'h006, 32'h0, 1'b0);
      repeat (10) waitfor(5, 1000);
      seq(8, ONE_RAIL_MASK);
      // A frozen stretch must not count towards the conversion slot.
      ce <= 1'b0;
      repeat (20) @(posedge pclk);
      ce <= 1'b1;
      waitfor(5, 1000);
      chk(32'(n), 32'(ADC_CYC));
      apb(1'b1, REG_CTRL, 32'h00F, 32'h0, 1'b0);
      apb(1'b1, 8'h40, 32'h80FFF100, 32'h0, 1'b0);
      v0 <= 12'h200;
      nvm_log <= 1'b1;
      waitfor(0, 8200);
      nvm_log <= 1'b0;
      chk(32'(en), 32'h2);
      waitfor(4, HIZ_CYC + 8);
      chk(32'(n > HIZ_CYC - 8), 32'h1);
      apb(1'b0, REG_STATUS, 32'h0, 32'h0090_0001, 1'b0);
      chk(rdv & 32'h0010_0001, 32'h0010_0001);
      apb(1'b0, 8'h80, 32'h0, 32'h2000_0200, 1'b0);
      fpin <= 2'b10;
      waitfor(1, 10);
      bclk <= 1'b0;
      waitfor(2, 310);
      chk(32'(n > 290), 32'h1);
      bclk <= 1'b1;
      bdat <= 1'b0;
      repeat (100) @(posedge pclk);
      bdat <= 1'b1;
      waitfor(3, 410);
      chk(32'(n > 390), 32'h1);
      presetn <= 1'b0;
      fpin <= 2'b00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      csc <= 2'b01;
      waitfor(0, 10);
      report_and_stop;
   end
endmodule
`default_nettype wire
